// >>> rtl/mog_pkg.sv
// package of the monitor output generator: register map, factory values, scaling and timing
// assumes a 25 MHz system clock and 16-bit quantities normalised to their full scale
package mog_pkg;
   // system clock
   localparam int CLK_HZ = 25000000;
   localparam int CLK_PERIOD_NS = 40;
   // register byte addresses
   localparam logic [7:0] ADDR_VOLT_SRC = 8'h00;
   localparam logic [7:0] ADDR_VOLT_GAIN = 8'h04;
   localparam logic [7:0] ADDR_VOLT_OFF = 8'h08;
   localparam logic [7:0] ADDR_CUR_SRC = 8'h0C;
   localparam logic [7:0] ADDR_CUR_GAIN = 8'h10;
   localparam logic [7:0] ADDR_CUR_OFF = 8'h14;
   localparam logic [7:0] ADDR_PULSE_SRC = 8'h18;
   localparam logic [7:0] ADDR_PULSE_GAIN = 8'h1C;
   localparam logic [7:0] ADDR_RUN_EDIT = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_VOLT_LEVEL = 8'h28;
   localparam logic [7:0] ADDR_CUR_LEVEL = 8'h2C;
   // field positions
   localparam int RUN_EDIT_EXT_BIT = 0;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_FM_BIT = 1;
   localparam int STAT_PULSE_BIT = 2;
   // factory values
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] VOLT_GAIN_RESET = 8'hB4;
   localparam logic [7:0] CUR_GAIN_RESET = 8'h50;
   localparam logic [7:0] PULSE_GAIN_RESET = 8'h3C;
   localparam logic [7:0] OFF_RESET = 8'h00;
   // source codes
   localparam logic [7:0] SRC_OUT_FREQ = 8'h00;
   localparam logic [7:0] SRC_OUT_CURRENT = 8'h01;
   localparam logic [7:0] SRC_FM_FREQ = 8'h03;
   localparam logic [7:0] SRC_OUT_VOLTAGE = 8'h04;
   localparam logic [7:0] SRC_IN_POWER = 8'h05;
   localparam logic [7:0] SRC_THERMAL = 8'h06;
   localparam logic [7:0] SRC_RAMP_FREQ = 8'h07;
   // levels: voltage in 10 mV steps, current in 10 uA steps, offsets in 0.1 units
   localparam int VOLT_FULL_CODE = 1000;
   localparam int VOLT_OFF_MAX = 100;
   localparam int CUR_ZERO_CODE = 400;
   localparam int CUR_SPAN_CODE = 1600;
   localparam int CUR_FULL_CODE = 2000;
   localparam int CUR_OFF_MAX = 200;
   localparam int OFF_STEP_CODE = 10;
   // pwm period and fm scaling (frequencies in 0.01 Hz)
   localparam int PWM_PERIOD_NS = 40000;
   localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FM_FREQ_MULT = 10;
   localparam int FM_MAX_CENTI_HZ = 400000;
   localparam logic [31:0] FM_MODULUS = 32'(64'd100 * 64'(CLK_HZ));
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> rtl/mog_pulse.sv
// pulse output generator: fixed-period pwm or 50 % duty frequency output
// assumes duty is at most the period and the fm step already capped
`timescale 1ns/10ps
module mog_pulse #(
   parameter int PERIOD = mog_pkg::PWM_PERIOD_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control and output
   mog_pulse_if.gen pif
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [31:0] acc;
      logic out;
   } mog_pulse_t;

   mog_pulse_t st;
   mog_pulse_t next_st;
   logic [31:0] sum;

   always_comb
   begin
      next_st = st;
      sum = st.acc + pif.fm_step;
      next_st.cnt = (st.cnt == 16'(PERIOD - 1)) ? 16'h0000 : st.cnt + 16'h0001;
      if (pif.fm_mode)
      begin
         // phase accumulator; upper half of FM_MODULUS gives an even square wave at any step
         next_st.acc = (sum >= mog_pkg::FM_MODULUS) ? sum - mog_pkg::FM_MODULUS : sum;
         next_st.out = next_st.acc >= (mog_pkg::FM_MODULUS >> 1);
      end
      else
      begin
         next_st.acc = 32'h00000000;
         next_st.out = st.cnt < pif.duty;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign pif.pulse = st.out;

   sequence pwm_period_start;
      !pif.fm_mode && st.cnt == 16'h0000 && pif.duty != 16'h0000;
   endsequence

   chk_pwm_high_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pwm_period_start |=> pif.pulse) else $error("pwm period did not start high");
   chk_pwm_zero_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !pif.fm_mode && pif.duty == 16'h0000 && $past(pif.duty) == 16'h0000 && !$past(pif.fm_mode)
      |-> !pif.pulse) else $error("pwm high with zero duty");
   chk_fm_acc_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st.acc < mog_pkg::FM_MODULUS) else $error("fm phase out of range");
endmodule // mog_pulse

// >>> rtl/mog_pulse_if.sv
// carrier between the register side and the pulse generator
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface mog_pulse_if;
   logic fm_mode;
   logic [15:0] duty;
   logic [31:0] fm_step;
   logic pulse;
   modport ctrl (output fm_mode, output duty, output fm_step, input pulse);
   modport gen (input fm_mode, input duty, input fm_step, output pulse);
endinterface

// >>> rtl/mog_scale.sv
// linear scaler: quantity times gain over unity gain, plus offset, clamped at full scale
// assumes q_i is a 16-bit fraction of full scale and unity_gain is non-zero
`timescale 1ns/10ps
module mog_scale #(
   parameter int BASE = 0,
   parameter int SPAN = 1000,
   parameter int FULL = 1000,
   parameter int OFF_STEP = 10,
   parameter int UNITY_GAIN = 180
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // settings and quantity
   input wire logic [15:0] q_i,
   input wire logic [7:0] gain_i,
   input wire logic [7:0] offset_i,
   // scaled level
   output logic [15:0] level_o
);
   typedef struct packed {
      logic [15:0] level;
   } mog_scale_t;

   mog_scale_t st;
   mog_scale_t next_st;
   logic [47:0] raw;

   always_comb
   begin
      raw = (48'(q_i) * 48'(gain_i) * 48'(SPAN)) / (48'd65535 * 48'(UNITY_GAIN));
      raw = raw + 48'(BASE) + 48'(offset_i) * 48'(OFF_STEP);
      next_st = st;
      // saturate instead of wrapping so a large gain pins the meter
      if (raw > 48'(FULL))
         next_st.level = 16'(FULL);
      else
         next_st.level = raw[15:0];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign level_o = st.level;

   chk_clamp_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      level_o <= 16'(FULL)) else $error("scaled level above full scale");
endmodule // mog_scale

// >>> rtl/mog_top.sv
// monitor output generator: voltage, current and pulse monitor outputs behind an axi4-lite slave
// assumes quantities arrive on clk_i as 16-bit fractions of full scale, run_i on clk_i too
`timescale 1ns/10ps
module mog_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // drive quantities and state
   input wire logic [15:0] q_out_freq_i,
   input wire logic [15:0] q_out_current_i,
   input wire logic [15:0] q_out_voltage_i,
   input wire logic [15:0] q_input_power_i,
   input wire logic [15:0] q_thermal_i,
   input wire logic [15:0] q_ramp_freq_i,
   input wire logic [15:0] out_freq_centi_hz_i,
   input wire logic run_i,
   // monitor outputs
   output logic [15:0] voltage_out_terminal_o,
   output logic [15:0] current_out_terminal_o,
   output logic pulse_out_terminal_o
);
   typedef struct packed {
      logic [7:0] volt_src;
      logic [7:0] volt_gain;
      logic [7:0] volt_off;
      logic [7:0] cur_src;
      logic [7:0] cur_gain;
      logic [7:0] cur_off;
      logic [7:0] pulse_src;
      logic [7:0] pulse_gain;
      logic ext_edit;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mog_regs_t;

   mog_regs_t st;
   mog_regs_t next_st;
   logic rst_meta;
   logic rst_n;
   logic do_write;
   logic write_ok;
   logic [15:0] volt_q;
   logic [15:0] cur_q;
   logic [15:0] pulse_q;
   logic [15:0] pwm_duty;
   logic [31:0] fm_raw;

   mog_pulse_if pif ();

   // reset enters asynchronously at assertion, leaves synchronously at release
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // valid codes of a source selector; code 03 only exists on the pulse output
   function automatic logic src_ok(input logic [7:0] code, input logic pulse_sel);
      case (code)
         mog_pkg::SRC_OUT_FREQ, mog_pkg::SRC_OUT_CURRENT, mog_pkg::SRC_OUT_VOLTAGE,
         mog_pkg::SRC_IN_POWER, mog_pkg::SRC_THERMAL, mog_pkg::SRC_RAMP_FREQ:
            src_ok = 1'b1;
         mog_pkg::SRC_FM_FREQ:
            src_ok = pulse_sel;
         default:
            src_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] pick(input logic [7:0] code);
      case (code)
         mog_pkg::SRC_OUT_FREQ, mog_pkg::SRC_FM_FREQ:
            pick = q_out_freq_i;
         mog_pkg::SRC_OUT_CURRENT:
            pick = q_out_current_i;
         mog_pkg::SRC_OUT_VOLTAGE:
            pick = q_out_voltage_i;
         mog_pkg::SRC_IN_POWER:
            pick = q_input_power_i;
         mog_pkg::SRC_THERMAL:
            pick = q_thermal_i;
         mog_pkg::SRC_RAMP_FREQ:
            pick = q_ramp_freq_i;
         default:
            pick = 16'h0000;
      endcase
   endfunction

   function automatic logic is_src_addr(input logic [7:0] addr);
      is_src_addr = addr == mog_pkg::ADDR_VOLT_SRC || addr == mog_pkg::ADDR_CUR_SRC ||
         addr == mog_pkg::ADDR_PULSE_SRC;
   endfunction

   always_comb volt_q = pick(st.volt_src);
   always_comb cur_q = pick(st.cur_src);
   always_comb pulse_q = pick(st.pulse_src);

   always_comb
   begin
      next_st = st;
      do_write = st.aw_held && st.w_held && !st.bvalid;
      write_ok = 1'b1;
      // write address and data are taken independently
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_held = 1'b1;
         next_st.wdata = s_axi_wdata[7:0];
         next_st.wstrb0 = s_axi_wstrb[0];
      end
      if (do_write)
      begin
         // selectors are locked while running unless extended editing is on
         if (is_src_addr(st.awaddr) && run_i && !st.ext_edit)
            write_ok = 1'b0;
         case (st.awaddr)
            mog_pkg::ADDR_VOLT_SRC, mog_pkg::ADDR_CUR_SRC:
               write_ok = write_ok && src_ok(st.wdata, 1'b0);
            mog_pkg::ADDR_PULSE_SRC:
               write_ok = write_ok && src_ok(st.wdata, 1'b1);
            mog_pkg::ADDR_VOLT_OFF:
               write_ok = st.wdata <= 8'(mog_pkg::VOLT_OFF_MAX);
            mog_pkg::ADDR_CUR_OFF:
               write_ok = st.wdata <= 8'(mog_pkg::CUR_OFF_MAX);
            mog_pkg::ADDR_VOLT_GAIN, mog_pkg::ADDR_CUR_GAIN, mog_pkg::ADDR_PULSE_GAIN,
            mog_pkg::ADDR_RUN_EDIT:
               write_ok = 1'b1;
            default:
               write_ok = 1'b0;
         endcase
         if (write_ok && st.wstrb0)
         begin
            case (st.awaddr)
               mog_pkg::ADDR_VOLT_SRC:
                  next_st.volt_src = st.wdata;
               mog_pkg::ADDR_VOLT_GAIN:
                  next_st.volt_gain = st.wdata;
               mog_pkg::ADDR_VOLT_OFF:
                  next_st.volt_off = st.wdata;
               mog_pkg::ADDR_CUR_SRC:
                  next_st.cur_src = st.wdata;
               mog_pkg::ADDR_CUR_GAIN:
                  next_st.cur_gain = st.wdata;
               mog_pkg::ADDR_CUR_OFF:
                  next_st.cur_off = st.wdata;
               mog_pkg::ADDR_PULSE_SRC:
                  next_st.pulse_src = st.wdata;
               mog_pkg::ADDR_PULSE_GAIN:
                  next_st.pulse_gain = st.wdata;
               mog_pkg::ADDR_RUN_EDIT:
                  next_st.ext_edit = st.wdata[mog_pkg::RUN_EDIT_EXT_BIT];
               default:
                  next_st.ext_edit = st.ext_edit;
            endcase
         end
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = write_ok ? mog_pkg::RESP_OKAY : mog_pkg::RESP_SLVERR;
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      // reads
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = mog_pkg::RESP_OKAY;
         next_st.rdata = 32'h00000000;
         case (s_axi_araddr)
            mog_pkg::ADDR_VOLT_SRC:
               next_st.rdata[7:0] = st.volt_src;
            mog_pkg::ADDR_VOLT_GAIN:
               next_st.rdata[7:0] = st.volt_gain;
            mog_pkg::ADDR_VOLT_OFF:
               next_st.rdata[7:0] = st.volt_off;
            mog_pkg::ADDR_CUR_SRC:
               next_st.rdata[7:0] = st.cur_src;
            mog_pkg::ADDR_CUR_GAIN:
               next_st.rdata[7:0] = st.cur_gain;
            mog_pkg::ADDR_CUR_OFF:
               next_st.rdata[7:0] = st.cur_off;
            mog_pkg::ADDR_PULSE_SRC:
               next_st.rdata[7:0] = st.pulse_src;
            mog_pkg::ADDR_PULSE_GAIN:
               next_st.rdata[7:0] = st.pulse_gain;
            mog_pkg::ADDR_RUN_EDIT:
               next_st.rdata[mog_pkg::RUN_EDIT_EXT_BIT] = st.ext_edit;
            mog_pkg::ADDR_STATUS:
            begin
               next_st.rdata[mog_pkg::STAT_RUN_BIT] = run_i;
               next_st.rdata[mog_pkg::STAT_FM_BIT] = pif.fm_mode;
               next_st.rdata[mog_pkg::STAT_PULSE_BIT] = pif.pulse;
            end
            mog_pkg::ADDR_VOLT_LEVEL:
               next_st.rdata[15:0] = voltage_out_terminal_o;
            mog_pkg::ADDR_CUR_LEVEL:
               next_st.rdata[15:0] = current_out_terminal_o;
            default:
               next_st.rresp = mog_pkg::RESP_SLVERR;
         endcase
      end
      else if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.volt_src <= mog_pkg::SRC_RESET;
         st.volt_gain <= mog_pkg::VOLT_GAIN_RESET;
         st.volt_off <= mog_pkg::OFF_RESET;
         st.cur_src <= mog_pkg::SRC_RESET;
         st.cur_gain <= mog_pkg::CUR_GAIN_RESET;
         st.cur_off <= mog_pkg::OFF_RESET;
         st.pulse_src <= mog_pkg::SRC_RESET;
         st.pulse_gain <= mog_pkg::PULSE_GAIN_RESET;
      end
      else
         st <= next_st;
   end

   // one write and one read in flight; address and data wait for the response
   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready = !st.w_held && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   mog_scale #(
      .BASE(0),
      .SPAN(mog_pkg::VOLT_FULL_CODE),
      .FULL(mog_pkg::VOLT_FULL_CODE),
      .OFF_STEP(mog_pkg::OFF_STEP_CODE),
      .UNITY_GAIN(int'(mog_pkg::VOLT_GAIN_RESET))
   ) u_volt_scale (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .q_i(volt_q),
      .gain_i(st.volt_gain),
      .offset_i(st.volt_off),
      .level_o(voltage_out_terminal_o)
   );

   mog_scale #(
      .BASE(mog_pkg::CUR_ZERO_CODE),
      .SPAN(mog_pkg::CUR_SPAN_CODE),
      .FULL(mog_pkg::CUR_FULL_CODE),
      .OFF_STEP(mog_pkg::OFF_STEP_CODE),
      .UNITY_GAIN(int'(mog_pkg::CUR_GAIN_RESET))
   ) u_cur_scale (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .q_i(cur_q),
      .gain_i(st.cur_gain),
      .offset_i(st.cur_off),
      .level_o(current_out_terminal_o)
   );

   // the pwm high time is the scaled level in clock cycles
   mog_scale #(
      .BASE(0),
      .SPAN(mog_pkg::PWM_PERIOD_CYC),
      .FULL(mog_pkg::PWM_PERIOD_CYC),
      .OFF_STEP(0),
      .UNITY_GAIN(int'(mog_pkg::PULSE_GAIN_RESET))
   ) u_pwm_scale (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .q_i(pulse_q),
      .gain_i(st.pulse_gain),
      .offset_i(8'h00),
      .level_o(pwm_duty)
   );

   // frequency output bypasses gain and offset entirely
   assign fm_raw = 32'(out_freq_centi_hz_i) * 32'(mog_pkg::FM_FREQ_MULT);
   assign pif.fm_mode = st.pulse_src == mog_pkg::SRC_FM_FREQ;
   assign pif.duty = pwm_duty;
   assign pif.fm_step = (fm_raw > 32'(mog_pkg::FM_MAX_CENTI_HZ)) ?
      32'(mog_pkg::FM_MAX_CENTI_HZ) : fm_raw;

   mog_pulse #(
      .PERIOD(mog_pkg::PWM_PERIOD_CYC)
   ) u_pulse (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .pif(pif)
   );

   assign pulse_out_terminal_o = pif.pulse;

   sequence src_write_locked;
      do_write && is_src_addr(st.awaddr) && run_i && !st.ext_edit;
   endsequence

   chk_src_run_lock: assert property (@(posedge clk_i) disable iff (!rst_n)
      src_write_locked |=> $stable(st.volt_src) && $stable(st.cur_src) && $stable(st.pulse_src)
      && s_axi_bresp == mog_pkg::RESP_SLVERR) else $error("source changed while locked");
   chk_gain_run_edit: assert property (@(posedge clk_i) disable iff (!rst_n)
      do_write && st.awaddr == mog_pkg::ADDR_VOLT_GAIN && st.wstrb0
      |=> st.volt_gain == $past(st.wdata)) else $error("gain write lost");
   chk_ext_src_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      do_write && st.awaddr == mog_pkg::ADDR_PULSE_SRC && st.ext_edit && st.wstrb0 &&
      src_ok(st.wdata, 1'b1) |=> st.pulse_src == $past(st.wdata))
      else $error("extended source write lost");
   chk_fm_only_03: assert property (@(posedge clk_i) disable iff (!rst_n)
      pif.fm_mode == (st.pulse_src == 8'h03)) else $error("fm mode on wrong code");
   chk_cur_range: assert property (@(posedge clk_i) disable iff (!rst_n)
      $past(rst_n) |-> current_out_terminal_o >= 16'(mog_pkg::CUR_ZERO_CODE)
      && current_out_terminal_o <= 16'(mog_pkg::CUR_FULL_CODE))
      else $error("current level outside 4 to 20 mA");
   chk_fm_ceiling: assert property (@(posedge clk_i) disable iff (!rst_n)
      pif.fm_step <= 32'd400000) else $error("fm step above 4 kHz");
   chk_bresp_after: assert property (@(posedge clk_i) disable iff (!rst_n)
      do_write |=> s_axi_bvalid) else $error("no write response");
endmodule // mog_top

// >>> sim/mog_meter.sv
// frequency meter model on the pulse output: high time and period in clock cycles
// assumes the pulse is sampled on the system clock
`timescale 1ns/10ps
module mog_meter (
   // clock and pulse
   input wire logic clk_i,
   input wire logic pulse_i,
   // last complete period
   output int hi_o,
   output int per_o
);
   int h = 0;
   int c = 0;
   logic p = 1'b0;
   initial hi_o = 0;
   initial per_o = 0;
   // a period is measured from one rising edge to the next
   always @(posedge clk_i)
   begin
      p <= pulse_i;
      c <= c + 1;
      h <= h + int'(pulse_i);
      if (pulse_i && !p)
      begin
         per_o <= c;
         hi_o <= h;
         c <= 1;
         h <= 1;
      end
   end
endmodule // mog_meter

// >>> sim/tb_top.sv
// self-checking bench of the monitor output generator
// assumes a meter model on the pulse output and a 25 MHz clock
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0, resetn_i = 1'b0, run_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic awready, wready, bvalid, arready, rvalid, pulse;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] q [6] = '{default: 16'h0000};
   logic [15:0] fcent = 16'h0000;
   logic [15:0] vlev, clev;
   logic [5:0] qf;
   int error_cnt = 0, n_tests = 0, hi, per, sv, sc;
   int mdl [8] = '{0, 180, 0, 0, 80, 0, 0, 60};
   int cd [6] = '{0, 1, 4, 5, 6, 7};
   localparam logic [1:0] OK = mog_pkg::RESP_OKAY;
   localparam logic [1:0] ER = mog_pkg::RESP_SLVERR;

   mog_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .q_out_freq_i(q[0]), .q_out_current_i(q[1]),
      .q_out_voltage_i(q[2]), .q_input_power_i(q[3]), .q_thermal_i(q[4]),
      .q_ramp_freq_i(q[5]), .out_freq_centi_hz_i(fcent), .run_i(run_i),
      .voltage_out_terminal_o(vlev), .current_out_terminal_o(clev),
      .pulse_out_terminal_o(pulse));
   mog_meter meter (.clk_i(clk_i), .pulse_i(pulse), .hi_o(hi), .per_o(per));

   initial forever #20 clk_i = ~clk_i;

   task automatic give_verdict;
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
      n_tests++;
      if ($isunknown(g) || (g !== e && !(tol > 0 && g + tol >= e && g <= e + tol)))
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // handshakes are judged before the edge so the release lands right after it
   task automatic axw(input logic [7:0] a, input int d, input logic [1:0] er);
      logic ha, hw, hb;
      // one edge between calls so bready is never lowered and raised in one step
      @(posedge clk_i);
      awaddr <= a;
      wdata <= 32'(d[7:0]);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
         @(negedge clk_i);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         if (hb) chk(bresp, er, 0);
         @(posedge clk_i);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (er == OK && a < 8'h20) mdl[a[4:2]] = d;
   endtask

   task automatic axr(input logic [7:0] a, input int ed, input logic [1:0] er);
      logic ha, hr;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr)
      begin
         @(negedge clk_i);
         ha = arvalid && arready;
         hr = rvalid;
         if (hr) chk(rdata, ed, 0);
         if (hr) chk(rresp, er, 0);
         @(posedge clk_i);
         if (ha) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   function automatic int lvl(bit f, int g, int un, int sp, int b, int off, int full);
      int v;
      v = (f ? g * sp / un : 0) + b + off * 10;
      return v > full ? full : v;
   endfunction

   initial
   begin
      repeat (100000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(31877));
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 8; i++) axr(8'(4 * i), mdl[i], OK);
      axr(8'h30, 0, ER);
      chk(clev, 400, 0);
      for (int i = 0; i < 6; i++)
      begin
         qf = 6'($urandom);
         for (int k = 0; k < 6; k++) q[k] <= qf[k] ? 16'hFFFF : 16'h0000;
         sv = $urandom % 6;
         sc = $urandom % 6;
         axw(mog_pkg::ADDR_VOLT_SRC, cd[sv], OK);
         axw(mog_pkg::ADDR_CUR_SRC, cd[sc], OK);
         axw(mog_pkg::ADDR_VOLT_GAIN, 9 * ($urandom % 29), OK);
         axw(mog_pkg::ADDR_CUR_GAIN, $urandom % 256, OK);
         axw(mog_pkg::ADDR_VOLT_OFF, $urandom % 101, OK);
         axw(mog_pkg::ADDR_CUR_OFF, $urandom % 201, OK);
         repeat (3) @(posedge clk_i);
         chk(vlev, lvl(qf[sv], mdl[1], 180, 1000, 0, mdl[2], 1000), 0);
         chk(clev, lvl(qf[sc], mdl[4], 80, 1600, 400, mdl[5], 2000), 0);
      end
      axr(mog_pkg::ADDR_VOLT_LEVEL, lvl(qf[sv], mdl[1], 180, 1000, 0, mdl[2], 1000), OK);
      axr(mog_pkg::ADDR_CUR_LEVEL, lvl(qf[sc], mdl[4], 80, 1600, 400, mdl[5], 2000), OK);
      axw(mog_pkg::ADDR_VOLT_SRC, 3, ER);
      axw(mog_pkg::ADDR_CUR_SRC, 2, ER);
      axw(mog_pkg::ADDR_VOLT_OFF, 101, ER);
      axw(mog_pkg::ADDR_CUR_OFF, 201, ER);
      axr(mog_pkg::ADDR_VOLT_OFF, mdl[2], OK);
      run_i <= 1'b1;
      axw(mog_pkg::ADDR_PULSE_GAIN, 30, OK);
      axw(mog_pkg::ADDR_PULSE_SRC, 1, ER);
      axw(mog_pkg::ADDR_RUN_EDIT, 1, OK);
      axw(mog_pkg::ADDR_PULSE_SRC, 4, OK);
      run_i <= 1'b0;
      for (int k = 0; k < 6; k++) q[k] <= 16'hFFFF;
      // a new gain per code, so a code that wrongly left pwm shows a stale high time
      for (int i = 0; i < 6; i++)
      begin
         axw(mog_pkg::ADDR_PULSE_GAIN, 8 * (i + 1), OK);
         axw(mog_pkg::ADDR_PULSE_SRC, cd[i], OK);
         repeat (2200) @(posedge clk_i);
         chk(per, 1000, 1);
         chk(hi, lvl(1'b1, mdl[7], 60, 1000, 0, 0, 1000), 1);
      end
      axw(mog_pkg::ADDR_PULSE_GAIN, 0, OK);
      axw(mog_pkg::ADDR_PULSE_SRC, 3, OK);
      fcent <= 16'd20000;
      repeat (37500) @(posedge clk_i);
      chk(per, 12500, 3);
      chk(hi, 6250, 3);
      fcent <= 16'hFFFF;
      repeat (19000) @(posedge clk_i);
      chk(per, 6250, 3);
      chk(hi, 3125, 3);
      give_verdict();
   end
endmodule // tb_top
